/* logic/hpl_pkg.sv */
package hpl_pkg;

   // ------------------------------------------------------------
   // Host port personalities and boot sources
   // ------------------------------------------------------------
   localparam logic [1:0] PORT_PARALLEL = 2'h0;
   localparam logic [1:0] PORT_SDIO     = 2'h1;
   localparam logic [1:0] PORT_ULPI     = 2'h2;
   localparam logic [1:0] PORT_RESERVED = 2'h3;
   localparam logic       BOOT_EEPROM   = 1'h0;
   localparam logic       BOOT_HOST     = 1'h1;

   // ------------------------------------------------------------
   // APB register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] A_STATUS   = 8'h00;
   localparam logic [7:0] A_CONTROL  = 8'h04;
   localparam logic [7:0] A_IRQ_STAT = 8'h08;
   localparam logic [7:0] A_IRQ_MASK = 8'h0c;
   localparam logic [7:0] A_LOADCNT  = 8'h10;
   localparam logic [7:0] A_IMAGELEN = 8'h14;
   localparam logic [7:0] A_IMEM_RD  = 8'h18;

   // Control bits
   localparam int C_WIDE16 = 0;
   localparam int C_IOMODE = 1;
   localparam int C_HIRQ   = 2;
   // Interrupt status bits
   localparam int I_LOADED = 0;
   localparam int I_PDATA  = 1;
   localparam int I_ERROR  = 2;
   localparam int NIRQ     = 3;

   // ------------------------------------------------------------
   // Sizes, reset values and timing
   // ------------------------------------------------------------
   localparam int          IMEM_WORDS   = 256;
   localparam int          IMEM_AW      = 8;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          FIFO_AW      = 4;
   localparam logic [15:0] IMAGELEN_RST = 16'h0100;
   localparam logic [31:0] CONTROL_RST  = 32'h0000_0001;
   localparam int          SPI_DIV      = 4;
   localparam logic [7:0]  SPI_READ_CMD = 8'h03;
   localparam int          CLK_MHZ      = 250;

   // ------------------------------------------------------------
   // Parallel port register offsets (ten registers, address[3:0])
   // ------------------------------------------------------------
   localparam logic [3:0] P_DATA   = 4'h0;
   localparam logic [3:0] P_STATUS = 4'h1;
   localparam int         P_NREG   = 10;
   localparam logic [10:0] CFG_BASE = 11'h200;

endpackage

/* logic/hpl_loader.sv */
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module hpl_loader (
   input  wire logic        CLOCK,
   input  wire logic        SRST,
   input  wire logic        CARD_RESET_N,
   input  wire logic [1:0]  HOST_PORT_SELECT_STRAPS,
   input  wire logic        HOST_BOOT_STRAP,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             IRQ,
   output logic             SPI_SCLK,
   output logic             SPI_CS_N,
   output logic             SPI_MOSI,
   input  wire logic        SPI_MISO,
   input  wire logic [10:0] HP_ADDR,
   input  wire logic        ATTRIBUTE_SPACE_SELECT_N,
   input  wire logic        HP_CS_N,
   input  wire logic        HP_RD_N,
   input  wire logic        HP_WR_N,
   input  wire logic [15:0] HP_DATA_IN,
   output logic      [15:0] HP_DATA_OUT,
   output logic             HP_DATA_OE,
   output logic             HP_IRQ_N,
   output logic             HP_IRQ_OE,
   input  wire logic        HOST_IMG_VALID,
   input  wire logic [31:0] HOST_IMG_DATA,
   output logic             HOST_IMG_READY,
   output logic      [1:0]  PORT_MODE,
   output logic             PORT_PARALLEL_EN,
   output logic             PORT_SDIO_EN,
   output logic             PORT_ULPI_EN,
   output logic             BOOT_DONE
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [1:0]  rst_s_r;
   logic [1:0]  miso_s_r;
   logic [1:0]  rd_s_r;
   logic [1:0]  wr_s_r;
   logic [1:0]  cs_s_r;
   logic [1:0]  rdm_r;
   logic [1:0]  wrm_r;
   logic [31:0] hdat_m_r;
   logic [31:0] hdat_s_r;
   logic        cr_n;
   logic        miso;
   logic [5:0]  strap_s_r;

   always_ff @(posedge CLOCK) begin
      strap_s_r <= {strap_s_r[2:0], HOST_BOOT_STRAP, HOST_PORT_SELECT_STRAPS};
      rst_s_r  <= {rst_s_r[0], CARD_RESET_N};
      miso_s_r <= {miso_s_r[0], SPI_MISO};
      cs_s_r   <= {cs_s_r[0], HP_CS_N};
      rd_s_r   <= {rd_s_r[0], HP_RD_N};
      wr_s_r   <= {wr_s_r[0], HP_WR_N};
   end
   assign cr_n = rst_s_r[1];
   assign miso = miso_s_r[1];

   // ------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------
   logic       cr_n_d_r;
   logic [1:0] mode_r;
   logic       boot_src_r;
   logic       go_r;
   logic       rel;

   assign rel = cr_n & ~cr_n_d_r;
   // Straps are read only at the release edge; later changes are ignored
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         cr_n_d_r   <= 1'b0;
         mode_r     <= hpl_pkg::PORT_RESERVED;
         boot_src_r <= hpl_pkg::BOOT_EEPROM;
         go_r       <= 1'b0;
      end else begin
         cr_n_d_r <= cr_n;
         go_r     <= rel;
         if (rel) begin
            mode_r     <= strap_s_r[4:3];
            boot_src_r <= strap_s_r[5];
         end
      end
   end

   assign PORT_MODE        = mode_r;
   assign PORT_PARALLEL_EN = (mode_r == hpl_pkg::PORT_PARALLEL);
   assign PORT_SDIO_EN     = (mode_r == hpl_pkg::PORT_SDIO);
   assign PORT_ULPI_EN     = (mode_r == hpl_pkg::PORT_ULPI);

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   localparam int NI = hpl_pkg::NIRQ;
   localparam int IA = hpl_pkg::IMEM_AW;
   logic [31:0] ctrl_r;
   logic [15:0] len_r;
   logic [NI-1:0] istat_r;
   logic [NI-1:0] imask_r;
   logic [NI-1:0] ev;
   logic        wr_acc;
   logic [IA-1:0] rdptr_r;

   assign wr_acc = PSEL & PENABLE & PWRITE;
   assign PREADY = 1'b1;

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ctrl_r  <= hpl_pkg::CONTROL_RST;
         len_r   <= hpl_pkg::IMAGELEN_RST;
         imask_r <= '0;
         rdptr_r <= '0;
      end else if (wr_acc) begin
         case (PADDR)
            hpl_pkg::A_CONTROL:  ctrl_r  <= PWDATA;
            hpl_pkg::A_IRQ_MASK: imask_r <= PWDATA[NI-1:0];
            hpl_pkg::A_IMAGELEN: len_r   <= PWDATA[15:0];
            hpl_pkg::A_IMEM_RD:  rdptr_r <= PWDATA[IA-1:0];
            default: ;
         endcase
      end
   end

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         istat_r <= '0;
      end else begin
         istat_r <= (istat_r & ~((wr_acc && PADDR == hpl_pkg::A_IRQ_STAT)
                                 ? PWDATA[NI-1:0] : '0)) | ev;
      end
   end
   assign IRQ = |(istat_r & imask_r);

   // ------------------------------------------------------------
   // Firmware loader
   // ------------------------------------------------------------
   typedef enum {L_IDLE, L_CMD, L_SPI, L_HOST, L_DONE, L_FAIL} hpl_ld_t;
   hpl_ld_t       st_r;
   logic [31:0]   imem [hpl_pkg::IMEM_WORDS];
   logic [IA:0]   wcnt_r;
   logic [31:0]   sh_r;
   logic [5:0]    bit_r;
   logic [2:0]    div_r;
   logic          tick;
   logic          wr_word;
   logic [31:0]   wdata;
   logic          done_r;
   logic [31:0]   rd_word_r;
   logic          pimg_v_r;
   logic [31:0]   pimg_r;

   assign tick = (div_r == 3'(hpl_pkg::SPI_DIV - 1));
   assign HOST_IMG_READY = (st_r == L_HOST) & ~PORT_PARALLEL_EN;
   assign wr_word = (st_r == L_SPI && tick && SPI_SCLK && bit_r == 6'd31)
                  | (HOST_IMG_VALID & HOST_IMG_READY)
                  | (st_r == L_HOST && PORT_PARALLEL_EN && pimg_v_r);
   assign wdata = (st_r == L_SPI) ? sh_r
                : (PORT_PARALLEL_EN ? pimg_r : HOST_IMG_DATA);

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         st_r     <= L_IDLE;
         wcnt_r   <= '0;
         sh_r     <= '0;
         bit_r    <= '0;
         div_r    <= '0;
         SPI_SCLK <= 1'b0;
         SPI_CS_N <= 1'b1;
         done_r   <= 1'b0;
      end else begin
         div_r <= tick ? 3'h0 : div_r + 3'h1;
         if (!cr_n) begin
            st_r     <= L_IDLE;
            SPI_CS_N <= 1'b1;
            SPI_SCLK <= 1'b0;
            done_r   <= 1'b0;
         end else begin
            case (st_r)
               L_IDLE: if (go_r) begin
                  wcnt_r <= '0;
                  bit_r  <= '0;
                  if (boot_src_r == hpl_pkg::BOOT_HOST) begin
                     st_r <= (mode_r == hpl_pkg::PORT_RESERVED) ? L_FAIL : L_HOST;
                  end else begin
                     st_r     <= L_CMD;
                     SPI_CS_N <= 1'b0;
                     sh_r     <= {hpl_pkg::SPI_READ_CMD, 24'h000000};
                  end
               end
               L_CMD: if (tick) begin
                  SPI_SCLK <= ~SPI_SCLK;
                  if (SPI_SCLK) begin
                     sh_r  <= {sh_r[30:0], 1'b0};
                     bit_r <= bit_r + 6'd1;
                     if (bit_r == 6'd31) begin
                        st_r  <= L_SPI;
                        bit_r <= '0;
                     end
                  end
               end
               L_SPI: if (tick) begin
                  SPI_SCLK <= ~SPI_SCLK;
                  if (!SPI_SCLK) begin
                     sh_r <= {sh_r[30:0], miso};
                  end else begin
                     bit_r <= (bit_r == 6'd31) ? 6'd0 : bit_r + 6'd1;
                     if (bit_r == 6'd31) begin
                        wcnt_r <= wcnt_r + 1'b1;
                        if (wcnt_r + 1'b1 >= (IA+1)'(len_r)) begin
                           st_r     <= L_DONE;
                           SPI_CS_N <= 1'b1;
                        end
                     end
                  end
               end
               L_HOST: if (wr_word) begin
                  wcnt_r <= wcnt_r + 1'b1;
                  if (wcnt_r + 1'b1 >= (IA+1)'(len_r)) st_r <= L_DONE;
               end
               L_DONE: done_r <= 1'b1;
               L_FAIL: done_r <= 1'b0;
               default: st_r <= L_IDLE;
            endcase
         end
      end
   end
   assign SPI_MOSI  = sh_r[31];
   assign BOOT_DONE = done_r;

   always_ff @(posedge CLOCK) begin
      if (wr_word && (st_r == L_SPI || st_r == L_HOST)) imem[wcnt_r[IA-1:0]] <= wdata;
      rd_word_r <= imem[rdptr_r];
   end

   assign ev[hpl_pkg::I_LOADED] = (st_r == L_DONE) & ~done_r;
   assign ev[hpl_pkg::I_ERROR]  = (st_r == L_IDLE) & go_r &
                                  (boot_src_r == hpl_pkg::BOOT_HOST) &
                                  (mode_r == hpl_pkg::PORT_RESERVED);

   // ------------------------------------------------------------
   // Parallel card port
   // ------------------------------------------------------------
   localparam int FA = hpl_pkg::FIFO_AW;
   logic [15:0] fifo [hpl_pkg::FIFO_DEPTH];
   logic [FA:0] wp_r;
   logic [FA:0] rp_r;
   logic        rd_e;
   logic        wr_e;
   logic        wide;
   logic        fempty;
   logic        ffull;
   logic        cfg_sp;
   logic [3:0]  rsel;
   logic [15:0] din;
   logic        lo_half_r;

   always_ff @(posedge CLOCK) begin
      rdm_r    <= {rdm_r[0], ~rd_s_r[1] & ~cs_s_r[1]};
      wrm_r    <= {wrm_r[0], ~wr_s_r[1] & ~cs_s_r[1]};
      hdat_m_r <= {4'h0, ATTRIBUTE_SPACE_SELECT_N, HP_ADDR, HP_DATA_IN};
      hdat_s_r <= hdat_m_r;
   end
   // Strobe edges arrive one cycle after data settles in hdat_s_r, so address/data are stable
   assign rd_e   = rdm_r[0] & ~rdm_r[1] & PORT_PARALLEL_EN;
   assign wr_e   = wrm_r[0] & ~wrm_r[1] & PORT_PARALLEL_EN;
   assign wide   = ctrl_r[hpl_pkg::C_WIDE16];
   assign din    = wide ? hdat_s_r[15:0] : {8'h00, hdat_s_r[7:0]};
   assign cfg_sp = ~hdat_s_r[27] | (hdat_s_r[26:16] >= hpl_pkg::CFG_BASE);
   assign rsel   = hdat_s_r[19:16];
   assign fempty = (wp_r == rp_r);
   assign ffull  = (wp_r == {~rp_r[FA], rp_r[FA-1:0]});

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         wp_r        <= '0;
         rp_r        <= '0;
         HP_DATA_OUT <= '0;
         HP_DATA_OE  <= 1'b0;
         pimg_v_r    <= 1'b0;
         pimg_r      <= '0;
         lo_half_r   <= 1'b1;
      end else begin
         pimg_v_r   <= 1'b0;
         HP_DATA_OE <= rdm_r[0] & PORT_PARALLEL_EN;
         if (wr_e && !cfg_sp && rsel == hpl_pkg::P_DATA) begin
            if (st_r == L_HOST) begin
               lo_half_r <= ~lo_half_r;
               if (lo_half_r) pimg_r[15:0] <= din;
               else begin
                  pimg_r[31:16] <= din;
                  pimg_v_r      <= 1'b1;
               end
            end else if (!ffull) begin
               fifo[wp_r[FA-1:0]] <= din;
               wp_r <= wp_r + 1'b1;
            end
         end
         if (rd_e) begin
            if (cfg_sp) HP_DATA_OUT <= {15'h0000, ctrl_r[hpl_pkg::C_IOMODE]};
            else if (rsel == hpl_pkg::P_DATA && !fempty) begin
               HP_DATA_OUT <= fifo[rp_r[FA-1:0]];
               rp_r        <= rp_r + 1'b1;
            end else if (rsel == hpl_pkg::P_STATUS)
               HP_DATA_OUT <= {12'h000, done_r, ffull, fempty, wide};
            else if (rsel < 4'(hpl_pkg::P_NREG))
               HP_DATA_OUT <= {12'h000, rsel};
            else HP_DATA_OUT <= '0;
         end
      end
   end
   assign ev[hpl_pkg::I_PDATA] = wr_e & ~cfg_sp & (rsel == hpl_pkg::P_DATA);

   // Host interrupt: level low, only driven in parallel mode
   assign HP_IRQ_N  = ctrl_r[hpl_pkg::C_HIRQ] ? fempty : ~done_r;
   assign HP_IRQ_OE = PORT_PARALLEL_EN;

   // ------------------------------------------------------------
   // APB read path
   // ------------------------------------------------------------
   always_comb begin
      PSLVERR = 1'b0;
      case (PADDR)
         hpl_pkg::A_STATUS:   PRDATA = {24'h000000, 1'b0, boot_src_r, mode_r,
                                        1'b0, 1'b0, fempty, done_r};
         hpl_pkg::A_CONTROL:  PRDATA = ctrl_r;
         hpl_pkg::A_IRQ_STAT: PRDATA = {29'h00000000, istat_r};
         hpl_pkg::A_IRQ_MASK: PRDATA = {29'h00000000, imask_r};
         hpl_pkg::A_LOADCNT:  PRDATA = {23'h000000, wcnt_r};
         hpl_pkg::A_IMAGELEN: PRDATA = {16'h0000, len_r};
         hpl_pkg::A_IMEM_RD:  PRDATA = rd_word_r;
         default: begin
            PRDATA  = '0;
            PSLVERR = PSEL & PENABLE;
         end
      endcase
   end

endmodule

/* tb/hpl_eeprom_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Serial boot memory on the SPI port
// ------------------------------------------------------------
module hpl_eeprom_model (
   input  wire logic sclk,
   input  wire logic cs_n,
   output logic      miso
);
   int          bit_cnt;
   logic [31:0] word;

   function automatic logic [31:0] ee_word(input logic [31:0] i);
      return {i[15:0] ^ 16'hc3a5, ~i[15:0]};
   endfunction

   initial miso = 1'b0;

   // Header is not decoded: the frame always starts at word 0
   always @(posedge sclk or posedge cs_n) begin
      if (cs_n)
         bit_cnt <= 0;
      else
         bit_cnt <= bit_cnt + 1;
   end

   // Mode 0 slave: shift on the falling edge, MSB first
   always @(negedge sclk or posedge cs_n) begin
      word = ee_word(32'((bit_cnt - 32) / 32));
      if (cs_n || bit_cnt < 32)
         miso <= ~miso;
      else
         miso <= word[31 - ((bit_cnt - 32) % 32)];
   end
endmodule

/* tb/hpl_loader_sva.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checks of the loader
// ------------------------------------------------------------
module hpl_loader_chk (
   input wire logic       CLOCK,
   input wire logic       SRST,
   input wire logic       CARD_RESET_N,
   input wire logic       HOST_BOOT_STRAP,
   input wire logic       HP_CS_N,
   input wire logic       HP_RD_N,
   input wire logic       SPI_SCLK,
   input wire logic       SPI_CS_N,
   input wire logic       SPI_MOSI,
   input wire logic       HP_DATA_OE,
   input wire logic       HP_IRQ_OE,
   input wire logic       HOST_IMG_READY,
   input wire logic [1:0] PORT_MODE,
   input wire logic       PORT_PARALLEL_EN,
   input wire logic       PORT_SDIO_EN,
   input wire logic       PORT_ULPI_EN,
   input wire logic       BOOT_DONE
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);

   // Half of the eight-cycle bit period
   sequence s_sclk_high;
      SPI_SCLK [*4] ##1 !SPI_SCLK;
   endsequence
   // Long enough past the capture delay of the strap sampler
   sequence s_reset_high;
      CARD_RESET_N [*8];
   endsequence

   a_mode_enables: assert property (
      PORT_PARALLEL_EN == (PORT_MODE == hpl_pkg::PORT_PARALLEL) &&
      PORT_SDIO_EN == (PORT_MODE == hpl_pkg::PORT_SDIO) &&
      PORT_ULPI_EN == (PORT_MODE == hpl_pkg::PORT_ULPI))
      else $error("port enables disagree with mode");
   a_reserved_quiet: assert property (
      PORT_MODE == hpl_pkg::PORT_RESERVED |->
      !(PORT_PARALLEL_EN || PORT_SDIO_EN || PORT_ULPI_EN || HP_DATA_OE || HP_IRQ_OE))
      else $error("reserved mode drives host side");
   a_mode_stable: assert property (s_reset_high |=> $stable(PORT_MODE))
      else $error("mode changed without reset edge");
   a_spi_boot_src: assert property (
      !SPI_CS_N |-> HOST_BOOT_STRAP == hpl_pkg::BOOT_EEPROM)
      else $error("spi active in host boot");
   a_cs_idle_clk: assert property (SPI_CS_N |-> !SPI_SCLK)
      else $error("spi clock high while deselected");
   a_sclk_high: assert property ($rose(SPI_SCLK) |-> s_sclk_high)
      else $error("spi clock high phase wrong");
   a_mosi_stable: assert property (
      SPI_SCLK && $past(SPI_SCLK) |-> $stable(SPI_MOSI))
      else $error("mosi moved while clock high");
   a_done_held: assert property (BOOT_DONE && CARD_RESET_N |=> BOOT_DONE)
      else $error("ready indication dropped");
   a_hpirq_parallel: assert property (
      HP_IRQ_OE |-> PORT_MODE == hpl_pkg::PORT_PARALLEL)
      else $error("host irq driven outside parallel mode");
   a_oe_on_read: assert property ($rose(HP_DATA_OE) |-> !HP_RD_N && !HP_CS_N)
      else $error("data bus driven without read");
   a_img_ready_host: assert property (
      HOST_IMG_READY |-> HOST_BOOT_STRAP == hpl_pkg::BOOT_HOST)
      else $error("image accepted outside host boot");
endmodule

bind hpl_loader hpl_loader_chk u_chk (
   .CLOCK, .SRST, .CARD_RESET_N, .HOST_BOOT_STRAP, .HP_CS_N, .HP_RD_N, .SPI_SCLK,
   .SPI_CS_N, .SPI_MOSI, .HP_DATA_OE, .HP_IRQ_OE, .HOST_IMG_READY, .PORT_MODE,
   .PORT_PARALLEL_EN, .PORT_SDIO_EN, .PORT_ULPI_EN, .BOOT_DONE
);

/* tb/hpl_loader_bench.sv */
`timescale 1ns/100ps
module hpl_loader_bench;
   logic        CLOCK = 1'b0;
   logic        SRST = 1'b1;
   logic        CARD_RESET_N = 1'b0;
   logic [1:0]  HOST_PORT_SELECT_STRAPS = 2'h0;
   logic        HOST_BOOT_STRAP = 1'b0;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic        PREADY, PSLVERR, IRQ, SPI_SCLK, SPI_CS_N, SPI_MOSI, SPI_MISO;
   logic [10:0] HP_ADDR = 11'h000;
   logic        ATTRIBUTE_SPACE_SELECT_N = 1'b1;
   logic        HP_CS_N = 1'b1;
   logic        HP_RD_N = 1'b1;
   logic        HP_WR_N = 1'b1;
   logic [15:0] HP_DATA_IN = 16'h0;
   logic [15:0] HP_DATA_OUT;
   logic        HP_DATA_OE, HP_IRQ_N, HP_IRQ_OE, HOST_IMG_READY;
   logic        HOST_IMG_VALID = 1'b0;
   logic [31:0] HOST_IMG_DATA = 32'h0;
   logic [1:0]  PORT_MODE;
   logic        PORT_PARALLEL_EN, PORT_SDIO_EN, PORT_ULPI_EN, BOOT_DONE;
   int          miscompares = 0;
   int          checked = 0;
   logic [31:0] seed = 32'h11c5c6db;
   logic [31:0] img [8];
   logic [15:0] fifo [17];
   logic [31:0] q;
   logic        err;

   always #2 CLOCK = ~CLOCK;

   hpl_loader dut (
      .CLOCK, .SRST, .CARD_RESET_N, .HOST_PORT_SELECT_STRAPS, .HOST_BOOT_STRAP, .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ, .SPI_SCLK,
      .SPI_CS_N, .SPI_MOSI, .SPI_MISO, .HP_ADDR, .ATTRIBUTE_SPACE_SELECT_N, .HP_CS_N,
      .HP_RD_N, .HP_WR_N, .HP_DATA_IN, .HP_DATA_OUT, .HP_DATA_OE, .HP_IRQ_N, .HP_IRQ_OE,
      .HOST_IMG_VALID, .HOST_IMG_DATA, .HOST_IMG_READY, .PORT_MODE, .PORT_PARALLEL_EN,
      .PORT_SDIO_EN, .PORT_ULPI_EN, .BOOT_DONE
   );
   hpl_eeprom_model u_ee (.sclk(SPI_SCLK), .cs_n(SPI_CS_N), .miso(SPI_MISO));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [31:0] ee_word(input logic [31:0] i);
      return {i[15:0] ^ 16'hc3a5, ~i[15:0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLOCK);
      end while (PREADY !== 1'b1);
      q = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   // Strobes are synchronised inside, so they are held well past the edge detector
   task automatic hp(input logic w, input logic attr_n, input logic [10:0] a,
                     input logic [15:0] d);
      HP_ADDR <= a;
      ATTRIBUTE_SPACE_SELECT_N <= attr_n;
      HP_DATA_IN <= d;
      HP_CS_N <= 1'b0;
      if (w)
         HP_WR_N <= 1'b0;
      else
         HP_RD_N <= 1'b0;
      repeat (10) @(posedge CLOCK);
      q = {16'h0, HP_DATA_OUT};
      err = HP_DATA_OE;
      HP_CS_N <= 1'b1;
      HP_WR_N <= 1'b1;
      HP_RD_N <= 1'b1;
      HP_DATA_IN <= ~d;
      repeat (6) @(posedge CLOCK);
   endtask
   task automatic boot(input logic [1:0] m, input logic src, input int len);
      CARD_RESET_N <= 1'b0;
      repeat (8) @(posedge CLOCK);
      HOST_PORT_SELECT_STRAPS <= m;
      HOST_BOOT_STRAP <= src;
      wr(hpl_pkg::A_CONTROL, 32'h1);
      wr(hpl_pkg::A_IMAGELEN, 32'(len));
      wr(hpl_pkg::A_IRQ_MASK, 32'h7);
      wr(hpl_pkg::A_IRQ_STAT, 32'h7);
      CARD_RESET_N <= 1'b1;
      repeat (16) @(posedge CLOCK);
      for (int i = 0; i < len && src && m != hpl_pkg::PORT_RESERVED; i++) begin
         seed = xs(seed);
         img[i] = seed;
         if (m == hpl_pkg::PORT_PARALLEL) begin
            hp(1'b1, 1'b1, 11'h000, img[i][15:0]);
            hp(1'b1, 1'b1, 11'h000, img[i][31:16]);
         end else begin
            HOST_IMG_VALID <= 1'b1;
            HOST_IMG_DATA <= img[i];
            do begin
               @(posedge CLOCK);
            end while (HOST_IMG_READY !== 1'b1);
         end
      end
      HOST_IMG_VALID <= 1'b0;
      while (BOOT_DONE !== 1'b1 && m != hpl_pkg::PORT_RESERVED) begin
         @(posedge CLOCK);
      end
      repeat (20) @(posedge CLOCK);
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge CLOCK);
      SRST <= 1'b0;
      @(posedge CLOCK);
      chk_rd(hpl_pkg::A_CONTROL, hpl_pkg::CONTROL_RST);
      chk_rd(hpl_pkg::A_IMAGELEN, {16'h0, hpl_pkg::IMAGELEN_RST});
      chk_rd(hpl_pkg::A_IRQ_STAT, 32'h0);
      check(32'(PORT_MODE), 32'(hpl_pkg::PORT_RESERVED));
      apb(1'b0, 8'h1c, 32'h0);
      check({31'h0, err}, 32'h1);
      check(q, 32'h0);
      $display("test reset_map done");
      boot(hpl_pkg::PORT_PARALLEL, hpl_pkg::BOOT_EEPROM, 8);
      check(32'(BOOT_DONE), 32'h1);
      check(32'({PORT_PARALLEL_EN, PORT_SDIO_EN, PORT_ULPI_EN}), 32'h4);
      chk_rd(hpl_pkg::A_STATUS, 32'h3);
      for (int i = 0; i < 8; i++) begin
         wr(hpl_pkg::A_IMEM_RD, 32'(i));
         chk_rd(hpl_pkg::A_IMEM_RD, ee_word(32'(i)));
      end
      chk_rd(hpl_pkg::A_LOADCNT, 32'h8);
      check(32'(IRQ), 32'h1);
      wr(hpl_pkg::A_IRQ_MASK, 32'h0);
      check(32'(IRQ), 32'h0);
      wr(hpl_pkg::A_IRQ_MASK, 32'h7);
      wr(hpl_pkg::A_IRQ_STAT, 32'h1);
      check(32'(IRQ), 32'h0);
      $display("test eeprom_boot done");
      for (int io = 0; io < 2; io++) begin
         wr(hpl_pkg::A_CONTROL, 32'h5 | 32'(io << 1));
         hp(1'b0, 1'b0, hpl_pkg::CFG_BASE, 16'h0);
         check(32'(q[0]), 32'(io));
         // One more word than the FIFO holds: the last is dropped
         for (int i = 0; i < 17; i++) begin
            seed = xs(seed);
            fifo[i] = seed[15:0];
            hp(1'b1, 1'b1, 11'(hpl_pkg::P_DATA), fifo[i]);
         end
         check(32'({HP_IRQ_N, HP_IRQ_OE}), 32'h1);
         for (int i = 0; i < 16; i++) begin
            hp(1'b0, 1'b1, 11'(hpl_pkg::P_DATA), 16'h0);
            check(q, 32'(fifo[i]));
            check(32'(err), 32'h1);
         end
         chk_rd(hpl_pkg::A_STATUS, 32'h3);
         check(32'(HP_IRQ_N), 32'h1);
         for (int r = 2; r < hpl_pkg::P_NREG; r++) begin
            hp(1'b0, 1'b1, 11'(r), 16'h0);
            check(32'(q[7:0]), 32'(r));
         end
      end
      chk_rd(hpl_pkg::A_IRQ_STAT, 32'h2);
      wr(hpl_pkg::A_CONTROL, 32'h4);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         hp(1'b1, 1'b1, 11'(hpl_pkg::P_DATA), seed[15:0]);
         hp(1'b0, 1'b1, 11'(hpl_pkg::P_DATA), 16'h0);
         check(q, 32'(seed[7:0]));
      end
      $display("test parallel_port done");
      for (int m = 0; m < 4; m++) begin
         boot(2'(m), hpl_pkg::BOOT_HOST, 4);
         check(32'(PORT_MODE), 32'(m));
         check(32'({PORT_PARALLEL_EN, PORT_SDIO_EN, PORT_ULPI_EN}), 32'h4 >> m);
         if (m == 3) begin
            check(32'({HP_DATA_OE, HP_IRQ_OE}), 32'h0);
            chk_rd(hpl_pkg::A_IRQ_STAT, 32'h4);
         end else begin
            chk_rd(hpl_pkg::A_STATUS, 32'h43 | 32'(m << 4));
            for (int i = 0; i < 4; i++) begin
               wr(hpl_pkg::A_IMEM_RD, 32'(i));
               chk_rd(hpl_pkg::A_IMEM_RD, img[i]);
            end
         end
      end
      $display("test host_boot done");
      test_done();
   end

   initial begin
      repeat (40000) @(posedge CLOCK);
      miscompares++;
      test_done();
   end
endmodule
